// ### ems_bus_seq.sv
/*
  External memory bus sequencer with an AXI4-Lite register slave.
  Assumes a core that issues one access at a time on req_valid/req_ready,
  and external memory wired to the latch strobe, strobes and data pins.
*/
`timescale 1ns/10ps
// How it works
// R1 - Nonpage external cycle takes four system clocks; internal cycle one.
// R2 - Page mode one: hit lasts 1, 2 or 4 clocks, miss 2, 4 or 8.
// R3 - Page mode two speeds code fetches; data accesses keep their stretch timing of eight clocks or more.
// R4 - Latch strobe stays off for internal fetches unless its option is set.
// R5 - External code fetch pulses the latch strobe, except on a page-mode hit.
// R6 - Program store strobe only for external fetches, never internal.
// R7 - Three-bit stretch field in control register sets data access length.
// R8 - Codes 0 to 3 add 0 to 3 stretch cycles; 4 to 7 add 7 to 10.
// R9 - Each stretch cycle is four system clocks.
// R10 - Stretch zero: data access is two basic cycles, no stretch.
// R11 - Settings 1 to 3 lengthen data access by 1 to 3 stretch cycles.
// R12 - First stretch adds one clock setup, one clock hold and two clocks strobe.
// R13 - Settings 4 to 7 widen latch, setup, hold and strobe by a cycle each.
// R14 - Divide-by-one strobe width is 2 to 28 oscillator clocks.
// R15 - Strobe width in oscillator clocks scales with the divider mode.
// R16 - Stretch field sampled at access start and held for the access.
// R17 - Memory latches address on the latch strobe and answers within the strobe.
module ems_bus_seq
  import ems_pkg::*;
#(
  parameter int AXI_ADDR_W = 12
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic [1:0] req_type,
  input wire logic req_internal,
  input wire logic [15:0] req_addr,
  input wire logic [7:0] req_wdata,
  output logic rsp_done,
  output logic [7:0] rsp_rdata,
  output logic ale,
  output logic program_store_strobe_n,
  output logic rd_n,
  output logic wr_n,
  output logic [15:0] mem_addr,
  output logic [7:0] mem_data_o,
  output logic mem_data_oe,
  input wire logic [7:0] mem_data_i
);
  if (AXI_ADDR_W < 12) begin : g_chk
    $error("AXI_ADDR_W must be at least 12");
  end

  // Register index decode, shared by both bus paths
  function automatic logic [2:0] ems_decode(input logic [11:0] a);
    case (a)
      EMS_ADDR_CTRL: ems_decode = 3'h1;
      EMS_ADDR_MODE: ems_decode = 3'h2;
      EMS_ADDR_STAT: ems_decode = 3'h3;
      EMS_ADDR_WIDTH: ems_decode = 3'h4;
      default: ems_decode = 3'h0;
    endcase
  endfunction

  // Stretch code to stretch machine cycles
  function automatic logic [3:0] ems_cycles(input logic [2:0] code);
    // R8 code to cycles
    ems_cycles = code[2] ? ({1'b0, code} + EMS_STR_JUMP) : {1'b0, code};
  endfunction

  // Data strobe width in system clocks for a cycle count
  function automatic logic [5:0] ems_dstrobe(input logic [3:0] n);
    // R12 first stretch widens strobe from two to four clocks
    if (n == 4'h0) ems_dstrobe = EMS_D0_PHASE;
    else if (n <= EMS_STR_JUMP) ems_dstrobe = 6'(n) * EMS_SC_CLKS;
    // R13 one cycle onto strobe
    else ems_dstrobe = 6'(n - EMS_STR_JUMP) * EMS_SC_CLKS;
  endfunction

  logic [7:0] ctrl, next_ctrl;
  logic [7:0] mode, next_mode;
  logic aw_full, next_aw_full, w_full, next_w_full;
  logic [11:0] aw_addr, next_aw_addr;
  logic [7:0] w_data, next_w_data;
  logic w_lane0, next_w_lane0;
  logic next_bvalid, next_rvalid;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata, width_q;
  logic do_wr;
  logic [2:0] stretch_lat, next_stretch_lat;
  ems_state_e state, next_state;
  logic [5:0] cnt, next_cnt, t_ale, next_t_ale, t_set, next_t_set;
  logic [5:0] t_str, next_t_str, t_tot, next_t_tot;
  logic is_fetch, next_is_fetch, is_rd, next_is_rd, is_wr, next_is_wr;
  logic next_ale, next_program_store_strobe_n, next_rd_n, next_wr_n, next_oe, next_done;
  logic [15:0] next_mem_addr;
  logic [7:0] next_mem_data_o, next_rsp_rdata, page_hi, next_page_hi;
  logic page_ok, next_page_ok;
  logic [1:0] cap, next_cap;
  logic [7:0] din_meta, din_sync;
  logic [5:0] la, ls, lt, lh, pb;
  logic [3:0] sn;
  logic str_on, page_miss;

  // Strobe width in quarter oscillator clocks for the live setting
  always_comb begin
    logic [4:0] sh;
    sh = 5'h0;
    // R15 divider scaling
    case (ctrl[EMS_CTRL_CD_LSB +: 2])
      2'b00: sh = ctrl[EMS_CTRL_MULT_BIT] ? 5'h0 : 5'h1;
      2'b11: sh = 5'hc;
      default: sh = 5'h2;
    endcase
    // R14 width per stretch code
    width_q = 32'(ems_dstrobe(ems_cycles(ctrl[EMS_CTRL_STR_LSB +: 3]))) << sh;
  end

  // AXI4-Lite write and read paths
  assign s_axi_awready = !aw_full && !s_axi_bvalid;
  assign s_axi_wready = !w_full && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign do_wr = aw_full && w_full && !s_axi_bvalid;

  always_comb begin
    next_aw_full = aw_full;
    next_aw_addr = aw_addr;
    next_w_full = w_full;
    next_w_data = w_data;
    next_w_lane0 = w_lane0;
    next_bvalid = s_axi_bvalid && !s_axi_bready;
    next_bresp = s_axi_bresp;
    next_ctrl = ctrl;
    next_mode = mode;
    next_rvalid = s_axi_rvalid && !s_axi_rready;
    next_rdata = s_axi_rdata;
    next_rresp = s_axi_rresp;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_full = 1'b1;
      next_aw_addr = s_axi_awaddr[11:0];
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_full = 1'b1;
      next_w_data = s_axi_wdata[7:0];
      next_w_lane0 = s_axi_wstrb[0];
    end
    if (do_wr) begin
      next_aw_full = 1'b0;
      next_w_full = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = EMS_RESP_OKAY;
      case (ems_decode(aw_addr))
        // R7 stretch field rewrite
        3'h1: next_ctrl = w_lane0 ? w_data : ctrl;
        3'h2: next_mode = w_lane0 ? w_data : mode;
        3'h3, 3'h4: next_bresp = EMS_RESP_OKAY;
        default: next_bresp = EMS_RESP_SLVERR;
      endcase
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp = EMS_RESP_OKAY;
      case (ems_decode(s_axi_araddr[11:0]))
        3'h1: next_rdata = {24'h0, ctrl};
        3'h2: next_rdata = {24'h0, mode};
        3'h3: next_rdata = {25'h0, stretch_lat, page_ok, 2'h0, state == EMS_RUN};
        3'h4: next_rdata = width_q;
        default: begin
          next_rdata = 32'h0;
          next_rresp = EMS_RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full <= 1'b0;
      aw_addr <= 12'h0;
      w_full <= 1'b0;
      w_data <= 8'h0;
      w_lane0 <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= EMS_RESP_OKAY;
      ctrl <= EMS_CTRL_RST;
      mode <= EMS_MODE_RST;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= EMS_RESP_OKAY;
    end else begin
      aw_full <= next_aw_full;
      aw_addr <= next_aw_addr;
      w_full <= next_w_full;
      w_data <= next_w_data;
      w_lane0 <= next_w_lane0;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      ctrl <= next_ctrl;
      mode <= next_mode;
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
    end
  end

  // Data pins pass two flip-flops before use
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      din_meta <= 8'h0;
      din_sync <= 8'h0;
    end else begin
      din_meta <= mem_data_i;
      din_sync <= din_meta;
    end
  end

  // Phase lengths of the offered access
  always_comb begin
    sn = ems_cycles(ctrl[EMS_CTRL_STR_LSB +: 3]);
    case (mode[EMS_MODE_SEL_LSB +: 2])
      2'b00: pb = 6'h1;
      2'b10: pb = 6'h4;
      default: pb = 6'h2;
    endcase
    page_miss = !page_ok || (page_hi != req_addr[15:8]);
    la = 6'h0;
    ls = 6'h0;
    lt = 6'h0;
    lh = 6'h0;
    if (req_type == EMS_FETCH && req_internal) begin
      // R4 latch strobe on internal fetch
      la = mode[EMS_MODE_ALEI_BIT] ? 6'h1 : 6'h0;
      lh = mode[EMS_MODE_ALEI_BIT] ? 6'h0 : 6'h1;
    end else if (req_type == EMS_FETCH && mode[EMS_MODE_PAGE_BIT]) begin
      // R2 page hit and miss lengths
      la = page_miss ? pb : 6'h0;
      lt = pb;
    end else if (req_type == EMS_FETCH) begin
      // R1 four-clock nonpage fetch
      la = EMS_NP_ALE;
      ls = EMS_NP_SETUP;
      lt = EMS_NP_STROBE;
    end else begin
      // R3 data timing independent of page mode
      // R10 two basic cycles at zero
      la = EMS_D0_PHASE;
      ls = EMS_D0_PHASE;
      lh = EMS_D0_PHASE;
      // R12 one clock setup and hold
      if (sn != 4'h0) begin
        ls = ls + 6'h1;
        lh = lh + 6'h1;
      end
      // R13 widen latch, setup and hold
      if (sn > EMS_STR_JUMP) begin
        la = la + EMS_SC_CLKS;
        ls = ls + EMS_SC_CLKS;
        lh = lh + EMS_SC_CLKS;
      end
      // R9 R11 four clocks per stretch cycle
      lt = ems_dstrobe(sn);
    end
  end

  // Bus sequencer
  assign req_ready = (state == EMS_IDLE);

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_t_ale = t_ale;
    next_t_set = t_set;
    next_t_str = t_str;
    next_t_tot = t_tot;
    next_is_fetch = is_fetch;
    next_is_rd = is_rd;
    next_is_wr = is_wr;
    next_stretch_lat = stretch_lat;
    next_mem_addr = mem_addr;
    next_mem_data_o = mem_data_o;
    next_rsp_rdata = rsp_rdata;
    next_page_hi = page_hi;
    next_page_ok = page_ok;
    next_done = 1'b0;
    next_cap = {cap[0], 1'b0};
    if (state == EMS_IDLE && req_valid) begin
      next_state = EMS_RUN;
      next_cnt = 6'h0;
      next_t_ale = la;
      next_t_set = la + ls;
      next_t_str = la + ls + lt;
      next_t_tot = la + ls + lt + lh;
      // R6 strobe only for external fetch
      next_is_fetch = (req_type == EMS_FETCH) && !req_internal;
      next_is_rd = (req_type == EMS_DREAD);
      next_is_wr = (req_type == EMS_DWRITE);
      // R16 stretch held for access
      next_stretch_lat = ctrl[EMS_CTRL_STR_LSB +: 3];
      next_mem_addr = req_addr;
      next_mem_data_o = req_wdata;
      if (req_type == EMS_FETCH && !req_internal) begin
        next_page_hi = req_addr[15:8];
        next_page_ok = 1'b1;
      end else if (req_type != EMS_FETCH) begin
        next_page_ok = 1'b0;
      end
    end else if (state == EMS_RUN) begin
      next_cnt = cnt + 6'h1;
      // R17 mark last strobe clock
      if ((is_rd || is_fetch) && cnt + 6'h1 == t_str) begin
        next_cap[0] = 1'b1;
      end
      if (cnt + 6'h1 == t_tot) begin
        next_state = EMS_IDLE;
        next_done = 1'b1;
      end
    end
    // Pins of the last strobe clock reach the sync stage two clocks later
    if (cap[1]) begin
      next_rsp_rdata = din_sync;
    end
    str_on = (next_state == EMS_RUN) && next_cnt >= next_t_set && next_cnt < next_t_str;
    // R5 latch strobe for the first t_ale clocks of any access
    next_ale = (next_state == EMS_RUN) && next_cnt < next_t_ale;
    next_program_store_strobe_n = !(str_on && next_is_fetch);
    next_rd_n = !(str_on && next_is_rd);
    next_wr_n = !(str_on && next_is_wr);
    next_oe = (next_state == EMS_RUN) && next_is_wr;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= EMS_IDLE;
      cnt <= 6'h0;
      t_ale <= 6'h0;
      t_set <= 6'h0;
      t_str <= 6'h0;
      t_tot <= 6'h0;
      is_fetch <= 1'b0;
      is_rd <= 1'b0;
      is_wr <= 1'b0;
      stretch_lat <= 3'h0;
      mem_addr <= 16'h0;
      mem_data_o <= 8'h0;
      rsp_rdata <= 8'h0;
      page_hi <= 8'h0;
      page_ok <= 1'b0;
      cap <= 2'h0;
      rsp_done <= 1'b0;
      ale <= 1'b0;
      program_store_strobe_n <= 1'b1;
      rd_n <= 1'b1;
      wr_n <= 1'b1;
      mem_data_oe <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      t_ale <= next_t_ale;
      t_set <= next_t_set;
      t_str <= next_t_str;
      t_tot <= next_t_tot;
      is_fetch <= next_is_fetch;
      is_rd <= next_is_rd;
      is_wr <= next_is_wr;
      stretch_lat <= next_stretch_lat;
      mem_addr <= next_mem_addr;
      mem_data_o <= next_mem_data_o;
      rsp_rdata <= next_rsp_rdata;
      page_hi <= next_page_hi;
      page_ok <= next_page_ok;
      cap <= next_cap;
      rsp_done <= next_done;
      ale <= next_ale;
      program_store_strobe_n <= next_program_store_strobe_n;
      rd_n <= next_rd_n;
      wr_n <= next_wr_n;
      mem_data_oe <= next_oe;
    end
  end
endmodule // ems_bus_seq

// ### ems_bus_seq_asserts.sv
/*
  Port-level checker for the external memory bus sequencer.
  Assumes page mode and the internal-fetch latch option stay off.
*/
`timescale 1ns/10ps
module ems_bus_seq_asserts
  import ems_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic [1:0] req_type,
  input wire logic req_internal,
  input wire logic rsp_done,
  input wire logic ale,
  input wire logic program_store_strobe_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [15:0] mem_addr,
  input wire logic mem_data_oe
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic take;
  logic dat, next_dat;
  int len, sw, next_len, next_sw;
  function automatic int sw_of(int n);
    return n == 0 ? 2 : (n < 4 ? 4 * n : 4 * (n - 3));
  endfunction
  assign take = req_valid && req_ready;
  // Access length and strobe clocks since take
  always_comb begin
    next_len = take ? 0 : len + 1;
    next_sw = take ? 0 : sw + int'(!rd_n || !wr_n);
    next_dat = take ? (req_type != EMS_FETCH) : dat;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      len <= 0;
      sw <= 0;
      dat <= 0;
    end else begin
      len <= next_len;
      sw <= next_sw;
      dat <= next_dat;
    end
  end
  // Sequencer timing and AXI response checks
  a_int_quiet: assert property (take && req_type == EMS_FETCH && req_internal |=>
    program_store_strobe_n && !ale ##1 program_store_strobe_n && !ale && rsp_done) else $error("internal fetch");
  a_ext_fetch: assert property (take && req_type == EMS_FETCH && !req_internal |=> ale ##1
    !ale && program_store_strobe_n ##1 !program_store_strobe_n [*2] ##1 rsp_done) else $error("external fetch");
  a_data_len: assert property (rsp_done && dat |-> len % 4 == 0 && len >= 8 && len <= 48 &&
    !(len > 20 && len < 36) && sw == sw_of((len - 8) / 4)) else $error("data access length");
  a_no_program_store_strobe_data: assert property (take && req_type != EMS_FETCH |=>
    program_store_strobe_n [*8]) else $error("fetch strobe on data");
  a_write_oe: assert property (!wr_n |-> mem_data_oe) else $error("write data not driven");
  a_addr_hold: assert property (!take |=> $stable(mem_addr)) else $error("address moved");
  a_busy_refuse: assert property (take |=> !req_ready) else $error("ready while busy");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  a_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read late");
  c_write: cover property (take && req_type == EMS_DWRITE);
  c_read: cover property (take && req_type == EMS_DREAD);
  c_slverr: cover property (s_axi_bvalid && s_axi_bresp == EMS_RESP_SLVERR);
endmodule // ems_bus_seq_asserts

// ### ems_bus_seq_tb_top.sv
/*
  Self-checking bench for the bus sequencer with AXI4-Lite master.
  Assumes the memory model on the far side and divide-by-one clocking.
*/
`timescale 1ns/10ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin bad_count++; \
  $display("ERROR %0t got %0h exp %0h", $time, g, e); end end
module ems_bus_seq_tb_top
  import ems_pkg::*;
;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, req_valid, req_ready;
  logic req_internal, rsp_done, ale, program_store_strobe_n, rd_n, wr_n, mem_data_oe;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [2:0] s_axi_awprot, s_axi_arprot;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd, seed;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, req_type, rr;
  logic [15:0] req_addr, mem_addr, a;
  logic [7:0] req_wdata, rsp_rdata, mem_data_o, mem_data_i, d;
  logic [7:0] em [256];
  int bad_count, checks_done, cyc, ln, sw, al;
  ems_bus_seq ems_bus_seq_inst (.*);
  ems_mem_model ems_mem_model_inst (.*);
  // Clock
  initial begin
    aclk = 0;
    forever #5 aclk = ~aclk;
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic int nstr(int c);
    return c < 4 ? c : c + 3;
  endfunction
  function automatic int swx(int n);
    return n == 0 ? 2 : (n < 4 ? 4 * n : 4 * (n - 3));
  endfunction
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic axw(input logic [11:0] ad, input logic [31:0] dt);
    logic aw_t, w_t, b_t;
    @(posedge aclk);
    s_axi_awaddr <= ad;
    s_axi_wdata <= dt;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    // Handshakes sampled mid-cycle, acted on at the next edge
    do begin
      @(negedge aclk);
      aw_t = s_axi_awvalid && s_axi_awready;
      w_t = s_axi_wvalid && s_axi_wready;
      b_t = (s_axi_bvalid === 1'b1);
      rr = s_axi_bresp;
      @(posedge aclk);
      if (aw_t) s_axi_awvalid <= 0;
      if (w_t) s_axi_wvalid <= 0;
    end while (!b_t);
    s_axi_bready <= 0;
  endtask
  task automatic axr(input logic [11:0] ad);
    logic ar_t, r_t;
    @(posedge aclk);
    s_axi_araddr <= ad;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do begin
      @(negedge aclk);
      ar_t = s_axi_arvalid && s_axi_arready;
      r_t = (s_axi_rvalid === 1'b1);
      rr = s_axi_rresp;
      rd = s_axi_rdata;
      @(posedge aclk);
      if (ar_t) s_axi_arvalid <= 0;
    end while (!r_t);
    s_axi_rready <= 0;
  endtask
  // One core access; counts clocks, strobe and latch clocks
  task automatic acc(input logic [1:0] t, input logic i, input logic [15:0] ad, input logic [7:0] dt);
    logic q_t;
    @(posedge aclk);
    req_type <= t;
    req_internal <= i;
    req_addr <= ad;
    req_wdata <= dt;
    req_valid <= 1;
    do begin
      @(negedge aclk);
      q_t = (req_ready === 1'b1);
      @(posedge aclk);
    end while (!q_t);
    req_valid <= 0;
    ln = 0;
    sw = 0;
    al = 0;
    do begin
      @(negedge aclk);
      ln++;
      sw += int'(!rd_n || !wr_n || !program_store_strobe_n);
      al += int'(ale);
    end while (rsp_done !== 1'b1 && ln < 99);
    // Read data passes the pin sync, so it settles two clocks later
    repeat (2) @(negedge aclk);
  endtask
  // Hang guard
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 30000) begin
      bad_count++;
      tally_and_finish();
    end
  end
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, req_valid, req_internal} = 0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awprot, s_axi_arprot} = 0;
    s_axi_wstrb = 4'h1;
    {req_type, req_addr, req_wdata, a, d} = 0;
    aresetn = 0;
    seed = 32'h9f13;
    {bad_count, checks_done, cyc} = 0;
    for (int i = 0; i < 256; i++) em[i] = 8'(i) ^ 8'h5a;
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    axr(EMS_ADDR_CTRL);
    `CHK(rd, {24'h0, EMS_CTRL_RST})
    axr(EMS_ADDR_MODE);
    `CHK(rd, 32'h0)
    axr(12'h004);
    `CHK({rr, rd}, {EMS_RESP_SLVERR, 32'h0})
    axw(12'h004, 32'h7);
    `CHK(rr, EMS_RESP_SLVERR)
    $display("test regs done");
    for (int cd = 0; cd < 4; cd++) for (int m = 0; m < 2; m++) for (int c = 0; c < 8; c++) begin
      axw(EMS_ADDR_CTRL, 32'(cd * 64 + m * 8 + c));
      axr(EMS_ADDR_WIDTH);
      `CHK(rd, 32'(swx(nstr(c)) * (cd == 0 ? (m ? 1 : 2) : (cd == 3 ? 4096 : 4))))
    end
    $display("test width done");
    acc(EMS_FETCH, 1, 16'h0012, 8'h00);
    `CHK(ln * 100 + sw + al, 200)
    acc(EMS_FETCH, 0, 16'h1234, 8'h00);
    `CHK(ln * 100 + sw * 10 + al, 521)
    `CHK(rsp_rdata, em[8'h34])
    $display("test fetch done");
    for (int c = 0; c < 8; c++) begin
      a = 16'(xs());
      d = 8'(xs());
      axw(EMS_ADDR_CTRL, 32'(128 + c));
      acc(EMS_DWRITE, 0, a, d);
      em[a[7:0]] = d;
      `CHK(ln, 9 + 4 * nstr(c))
      `CHK(sw, swx(nstr(c)))
      `CHK(al, nstr(c) > 3 ? 6 : 2)
      acc(EMS_DREAD, 0, a, 8'h00);
      `CHK(ln, 9 + 4 * nstr(c))
      `CHK(rsp_rdata, em[a[7:0]])
    end
    $display("test stretch done");
    axw(EMS_ADDR_CTRL, 32'h87);
    fork
      acc(EMS_DREAD, 0, a, 8'h00);
      begin
        repeat (4) @(posedge aclk);
        axw(EMS_ADDR_CTRL, 32'h80);
      end
    join
    `CHK(ln, 49)
    acc(EMS_DREAD, 0, a, 8'h00);
    `CHK(ln, 9)
    axr(EMS_ADDR_CTRL);
    `CHK(rd, 32'h80)
    $display("test rewrite done");
    tally_and_finish();
  end
endmodule // ems_bus_seq_tb_top
bind ems_bus_seq ems_bus_seq_asserts ems_bus_seq_asserts_inst (.*);

// ### ems_mem_model.sv
/*
  External byte memory on the latch strobe and strobes.
  Assumes low address byte only; released bus shows inverse of last byte.
*/
`timescale 1ns/10ps
module ems_mem_model (
  input wire logic aclk,
  input wire logic ale,
  input wire logic program_store_strobe_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [15:0] mem_addr,
  input wire logic [7:0] mem_data_o,
  output logic [7:0] mem_data_i
);
  logic [7:0] mem [256];
  logic [7:0] lat = 8'h00;
  logic [7:0] last = 8'h00;
  initial begin
    for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5a;
  end
  always @(posedge aclk) begin
    if (ale) lat <= mem_addr[7:0];
    if (!wr_n) mem[lat] <= mem_data_o;
    if (!rd_n || !program_store_strobe_n) last <= mem[lat];
  end
  assign mem_data_i = (!rd_n || !program_store_strobe_n) ? mem[lat] : ~last;
endmodule // ems_mem_model

// ### ems_pkg.sv
/*
  Shared constants for the external memory bus sequencer: register
  indices and byte addresses, field positions, reset values, cycle counts.
  Assumes a 32-bit AXI4-Lite register bus and one system clock domain.
*/
package ems_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] EMS_IDX_CTRL = 8'h8e;
  localparam logic [7:0] EMS_IDX_MODE = 8'h90;
  localparam logic [7:0] EMS_IDX_STAT = 8'h91;
  localparam logic [7:0] EMS_IDX_WIDTH = 8'h92;
  localparam logic [11:0] EMS_ADDR_CTRL = {2'h0, EMS_IDX_CTRL, 2'h0};
  localparam logic [11:0] EMS_ADDR_MODE = {2'h0, EMS_IDX_MODE, 2'h0};
  localparam logic [11:0] EMS_ADDR_STAT = {2'h0, EMS_IDX_STAT, 2'h0};
  localparam logic [11:0] EMS_ADDR_WIDTH = {2'h0, EMS_IDX_WIDTH, 2'h0};
  // Reset values
  localparam logic [7:0] EMS_CTRL_RST = 8'h81;
  localparam logic [7:0] EMS_MODE_RST = 8'h00;
  // Field positions
  localparam int EMS_CTRL_STR_LSB = 0;
  localparam int EMS_CTRL_MULT_BIT = 3;
  localparam int EMS_CTRL_CD_LSB = 6;
  localparam int EMS_MODE_PAGE_BIT = 0;
  localparam int EMS_MODE_SEL_LSB = 1;
  localparam int EMS_MODE_ALEI_BIT = 3;
  // Cycle counts in system clocks; EMS_STR_JUMP in stretch cycles
  localparam logic [5:0] EMS_SC_CLKS = 6'h04;
  localparam logic [5:0] EMS_NP_ALE = 6'h01;
  localparam logic [5:0] EMS_NP_SETUP = 6'h01;
  localparam logic [5:0] EMS_NP_STROBE = 6'h02;
  localparam logic [5:0] EMS_D0_PHASE = 6'h02;
  localparam logic [3:0] EMS_STR_JUMP = 4'h3;
  // Bus responses
  localparam logic [1:0] EMS_RESP_OKAY = 2'h0;
  localparam logic [1:0] EMS_RESP_SLVERR = 2'h2;
  // Request kinds and sequencer states
  typedef enum logic [1:0] {EMS_FETCH, EMS_DREAD, EMS_DWRITE, EMS_RSVD} ems_req_e;
  typedef enum logic {EMS_IDLE, EMS_RUN} ems_state_e;
endpackage
